// *** common/vfs_pkg.sv ***
`default_nettype none
package vfs_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_FIELD_COUNT = 8'h2a;
	localparam logic [7:0] IDX_SLOTS_LOW   = 8'h2b;
	localparam logic [7:0] IDX_SLOTS_HIGH  = 8'h2c;
	localparam logic [7:0] IDX_UPDATE_LOW  = 8'hb4;
	localparam logic [7:0] IDX_UPDATE_HIGH = 8'hb5;
	localparam logic [7:0] IDX_CONTROL     = 8'hc0;
	localparam logic [7:0] IDX_STATUS      = 8'hc1;

	// Field widths.
	localparam int COUNT_W      = 3;
	localparam int SLOT_W       = 5;
	localparam int SLOTS_LOW_W  = 25;
	localparam int SLOTS_HIGH_W = 10;
	localparam int UPDATE_W     = 16;
	localparam int NUM_CHAN     = 11;

	// Reset values.
	localparam logic [2:0]  FIELD_COUNT_RST = 3'h1;
	localparam logic [24:0] SLOTS_LOW_RST   = 25'h0000000;
	localparam logic [9:0]  SLOTS_HIGH_RST  = 10'h000;
	localparam logic [15:0] UPDATE_RST      = 16'h0000;
	localparam logic        LEGACY_RST      = 1'b0;

	// Update-control pattern that makes the mode registers vertical-sync updated.
	localparam logic [15:0] UPDATE_LOW_SYNC   = 16'h03ff;
	localparam logic [15:0] UPDATE_HIGH_SYNC  = 16'hfc00;
	localparam logic [1:0]  SYNC_UPDATE_EDGES = 2'h2;

	// Control and status field positions.
	localparam int CTRL_LEGACY_BIT = 0;
	localparam int STAT_POS_LSB    = 0;
	localparam int STAT_FIELD_LSB  = 8;
	localparam int STAT_PEND_LSB   = 16;
	localparam int STAT_VDMODE_BIT = 20;

	// Register selector.
	typedef enum logic [2:0] {
		SEL_NONE        = 3'b000,
		SEL_FIELD_COUNT = 3'b001,
		SEL_SLOTS_LOW   = 3'b010,
		SEL_SLOTS_HIGH  = 3'b011,
		SEL_UPDATE_LOW  = 3'b100,
		SEL_UPDATE_HIGH = 3'b101,
		SEL_CONTROL     = 3'b110,
		SEL_STATUS      = 3'b111
	} reg_sel_e;

	// Driver level selection.
	typedef enum logic [1:0] {
		LEVEL_LOW    = 2'b00,
		LEVEL_MIDDLE = 2'b01,
		LEVEL_HIGH   = 2'b10
	} level_e;

endpackage
`default_nettype wire

// *** common/vdrv_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface vdrv_if;
	logic [8:1]           transfer_clock;
	logic [7:1]           sense_gate;
	logic                 vertical_signal_23;
	logic                 vertical_signal_24;
	logic                 general_output_5;
	logic                 general_output_6;
	logic                 legacy_channel_select;
	vfs_pkg::level_e      level [vfs_pkg::NUM_CHAN];

	modport source (
		output transfer_clock, sense_gate, vertical_signal_23, vertical_signal_24,
		output general_output_5, general_output_6, legacy_channel_select,
		input  level
	);
	modport decoder (
		input  transfer_clock, sense_gate, vertical_signal_23, vertical_signal_24,
		input  general_output_5, general_output_6, legacy_channel_select,
		output level
	);
endinterface
`default_nettype wire

// *** core/vdrv_level_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module vdrv_level_decoder (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Timing inputs and level outputs.
	vdrv_if.decoder   drv_io
);

	// Three-level decode: transfer high forces low, else the gate picks middle or high.
	function automatic vfs_pkg::level_e decode3(input logic xfer, input logic gate);
		if (xfer) begin
			return vfs_pkg::LEVEL_LOW;
		end
		return gate ? vfs_pkg::LEVEL_MIDDLE : vfs_pkg::LEVEL_HIGH;
	endfunction

	logic xfer [vfs_pkg::NUM_CHAN];
	logic gate [vfs_pkg::NUM_CHAN];
	logic lg;

	assign lg = drv_io.legacy_channel_select;

	// Channel order: 1a 1b 2a 2b 3a 3b 4 5 6 7 8.
	always_comb begin
		xfer[0]  = drv_io.transfer_clock[1];
		gate[0]  = drv_io.sense_gate[1];
		xfer[1]  = drv_io.transfer_clock[1];
		gate[1]  = drv_io.sense_gate[2];
		xfer[2]  = drv_io.transfer_clock[2];
		gate[2]  = drv_io.sense_gate[3];
		xfer[3]  = drv_io.transfer_clock[2];
		gate[3]  = drv_io.sense_gate[4];
		xfer[4]  = drv_io.transfer_clock[3];
		gate[4]  = drv_io.sense_gate[5];
		xfer[5]  = lg ? drv_io.vertical_signal_23 : drv_io.transfer_clock[3];
		gate[5]  = drv_io.sense_gate[6];
		xfer[6]  = drv_io.transfer_clock[4];
		gate[6]  = drv_io.sense_gate[7];
		xfer[7]  = drv_io.transfer_clock[5];
		gate[7]  = lg ? drv_io.general_output_5 : drv_io.vertical_signal_23;
		xfer[8]  = drv_io.transfer_clock[6];
		gate[8]  = lg ? drv_io.general_output_6 : drv_io.vertical_signal_24;
		xfer[9]  = drv_io.transfer_clock[7];
		gate[9]  = 1'b1;
		xfer[10] = drv_io.transfer_clock[8];
		gate[10] = 1'b1;
	end

	// A gate held high turns the three-level decode into the two-level one.
	for (genvar i = 0; i < vfs_pkg::NUM_CHAN; i++) begin : g_chan
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				drv_io.level[i] <= vfs_pkg::LEVEL_LOW;
			end else begin
				drv_io.level[i] <= decode3(xfer[i], gate[i]);
			end
		end
	end

endmodule
`default_nettype wire

// *** core/ccd_vertical_field_sequencer.sv ***
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ccd_vertical_field_sequencer (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Vertical sync pin.
	input  wire logic        vertical_sync,
	// Vertical timing inputs from the timing core.
	input  wire logic [8:1]  transfer_clock,
	input  wire logic [7:1]  sense_gate,
	input  wire logic        vertical_signal_23,
	input  wire logic        vertical_signal_24,
	input  wire logic        general_output_5,
	input  wire logic        general_output_6,
	// Field sequencer state.
	output logic      [4:0]  current_field,
	output logic      [2:0]  sequence_position,
	// Driver level selections.
	output logic      [1:0]  drive_channel_1a,
	output logic      [1:0]  drive_channel_1b,
	output logic      [1:0]  drive_channel_2a,
	output logic      [1:0]  drive_channel_2b,
	output logic      [1:0]  drive_channel_3a,
	output logic      [1:0]  drive_channel_3b,
	output logic      [1:0]  drive_channel_4,
	output logic      [1:0]  drive_channel_5,
	output logic      [1:0]  drive_channel_6,
	output logic      [1:0]  drive_channel_7,
	output logic      [1:0]  drive_channel_8
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	function automatic vfs_pkg::reg_sel_e decode_addr(input logic [31:0] addr);
		if (addr[1:0] != 2'h0 || addr[31:10] != 22'h000000) begin
			return vfs_pkg::SEL_NONE;
		end
		case (addr[9:2])
			vfs_pkg::IDX_FIELD_COUNT: return vfs_pkg::SEL_FIELD_COUNT;
			vfs_pkg::IDX_SLOTS_LOW:   return vfs_pkg::SEL_SLOTS_LOW;
			vfs_pkg::IDX_SLOTS_HIGH:  return vfs_pkg::SEL_SLOTS_HIGH;
			vfs_pkg::IDX_UPDATE_LOW:  return vfs_pkg::SEL_UPDATE_LOW;
			vfs_pkg::IDX_UPDATE_HIGH: return vfs_pkg::SEL_UPDATE_HIGH;
			vfs_pkg::IDX_CONTROL:     return vfs_pkg::SEL_CONTROL;
			vfs_pkg::IDX_STATUS:      return vfs_pkg::SEL_STATUS;
			default:                  return vfs_pkg::SEL_NONE;
		endcase
	endfunction

	vfs_pkg::reg_sel_e sel;
	logic              access;
	logic              wr_en;

	assign sel     = decode_addr(paddr);
	assign access  = psel & penable;
	assign pready  = 1'b1;
	assign pslverr = access & (sel == vfs_pkg::SEL_NONE);
	assign wr_en   = access & pwrite;

	////////////////////////////////////////////////////////////////////////////////
	// Vertical sync synchroniser and falling edge.

	logic vs_meta_q;
	logic vs_sync_q;
	logic vs_prev_q;
	logic vs_fall;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vs_meta_q <= 1'b0;
			vs_sync_q <= 1'b0;
			vs_prev_q <= 1'b0;
		end else begin
			vs_meta_q <= vertical_sync;
			vs_sync_q <= vs_meta_q;
			vs_prev_q <= vs_sync_q;
		end
	end

	assign vs_fall = vs_prev_q & ~vs_sync_q;

	////////////////////////////////////////////////////////////////////////////////
	// Software-written registers.

	logic [2:0]  count_sh_q;
	logic [24:0] slots_low_sh_q;
	logic [9:0]  slots_high_sh_q;
	logic [15:0] update_low_q;
	logic [15:0] update_high_q;
	logic        legacy_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_sh_q      <= vfs_pkg::FIELD_COUNT_RST;
			slots_low_sh_q  <= vfs_pkg::SLOTS_LOW_RST;
			slots_high_sh_q <= vfs_pkg::SLOTS_HIGH_RST;
		end else if (wr_en) begin
			unique case (sel)
				vfs_pkg::SEL_FIELD_COUNT: count_sh_q      <= pwdata[2:0];
				vfs_pkg::SEL_SLOTS_LOW:   slots_low_sh_q  <= pwdata[24:0];
				vfs_pkg::SEL_SLOTS_HIGH:  slots_high_sh_q <= pwdata[9:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			update_low_q  <= vfs_pkg::UPDATE_RST;
			update_high_q <= vfs_pkg::UPDATE_RST;
			legacy_q      <= vfs_pkg::LEGACY_RST;
		end else if (wr_en) begin
			unique case (sel)
				vfs_pkg::SEL_UPDATE_LOW:  update_low_q  <= pwdata[15:0];
				vfs_pkg::SEL_UPDATE_HIGH: update_high_q <= pwdata[15:0];
				vfs_pkg::SEL_CONTROL:     legacy_q      <= pwdata[vfs_pkg::CTRL_LEGACY_BIT];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode update timing.

	logic       vs_mode;
	logic       mode_wr;
	logic       high_wr;
	logic [1:0] pend_q;
	logic       reset_pend_q;
	logic       apply_vs;
	logic       counter_reset;

	assign vs_mode = (update_low_q == vfs_pkg::UPDATE_LOW_SYNC) &
	                 (update_high_q == vfs_pkg::UPDATE_HIGH_SYNC);
	assign mode_wr = wr_en & ((sel == vfs_pkg::SEL_FIELD_COUNT) |
	                          (sel == vfs_pkg::SEL_SLOTS_LOW) |
	                          (sel == vfs_pkg::SEL_SLOTS_HIGH));
	assign high_wr = wr_en & (sel == vfs_pkg::SEL_SLOTS_HIGH);

	// A new write restarts the two-edge wait, so the latest write always wins.
	assign apply_vs = vs_fall & (pend_q == 2'h1) & ~(mode_wr & vs_mode);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 2'h0;
		end else if (mode_wr & vs_mode) begin
			pend_q <= vfs_pkg::SYNC_UPDATE_EDGES;
		end else if (vs_fall && pend_q != 2'h0) begin
			pend_q <= pend_q - 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_pend_q <= 1'b0;
		end else if (high_wr & vs_mode) begin
			reset_pend_q <= 1'b1;
		end else if (apply_vs) begin
			reset_pend_q <= 1'b0;
		end
	end

	assign counter_reset = (high_wr & ~vs_mode) | (apply_vs & reset_pend_q);

	////////////////////////////////////////////////////////////////////////////////
	// Active mode registers.

	logic [2:0]  count_act_q;
	logic [24:0] slots_low_act_q;
	logic [9:0]  slots_high_act_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_act_q <= vfs_pkg::FIELD_COUNT_RST;
		end else if (wr_en && sel == vfs_pkg::SEL_FIELD_COUNT && !vs_mode) begin
			count_act_q <= pwdata[2:0];
		end else if (apply_vs) begin
			count_act_q <= count_sh_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slots_low_act_q <= vfs_pkg::SLOTS_LOW_RST;
		end else if (wr_en && sel == vfs_pkg::SEL_SLOTS_LOW && !vs_mode) begin
			slots_low_act_q <= pwdata[24:0];
		end else if (apply_vs) begin
			slots_low_act_q <= slots_low_sh_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slots_high_act_q <= vfs_pkg::SLOTS_HIGH_RST;
		end else if (high_wr & ~vs_mode) begin
			slots_high_act_q <= pwdata[9:0];
		end else if (apply_vs) begin
			slots_high_act_q <= slots_high_sh_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Field sequencer.

	logic [2:0]  pos_q;
	logic [2:0]  count_eff;
	logic [2:0]  pos_next;
	logic [34:0] all_slots;

	// A count of zero is outside the legal range and is held as one field.
	assign count_eff = (count_act_q == 3'h0) ? 3'h1 : count_act_q;
	assign pos_next  = (pos_q + 3'h1 >= count_eff) ? 3'h0 : pos_q + 3'h1;
	assign all_slots = {slots_high_act_q, slots_low_act_q};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_q <= 3'h0;
		end else if (counter_reset) begin
			pos_q <= 3'h0;
		end else if (vs_fall) begin
			pos_q <= pos_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			current_field <= 5'h00;
		end else begin
			current_field <= all_slots[pos_q * vfs_pkg::SLOT_W +: vfs_pkg::SLOT_W];
		end
	end

	assign sequence_position = pos_q;

	////////////////////////////////////////////////////////////////////////////////
	// Read data, captured in the setup cycle.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= 32'h00000000;
			unique case (sel)
				vfs_pkg::SEL_FIELD_COUNT: prdata[2:0]  <= count_sh_q;
				vfs_pkg::SEL_SLOTS_LOW:   prdata[24:0] <= slots_low_sh_q;
				vfs_pkg::SEL_SLOTS_HIGH:  prdata[9:0]  <= slots_high_sh_q;
				vfs_pkg::SEL_UPDATE_LOW:  prdata[15:0] <= update_low_q;
				vfs_pkg::SEL_UPDATE_HIGH: prdata[15:0] <= update_high_q;
				vfs_pkg::SEL_CONTROL:     prdata[vfs_pkg::CTRL_LEGACY_BIT] <= legacy_q;
				vfs_pkg::SEL_STATUS: begin
					prdata[vfs_pkg::STAT_POS_LSB +: 3]   <= pos_q;
					prdata[vfs_pkg::STAT_FIELD_LSB +: 5] <= current_field;
					prdata[vfs_pkg::STAT_PEND_LSB +: 2]  <= pend_q;
					prdata[vfs_pkg::STAT_VDMODE_BIT]     <= vs_mode;
				end
				vfs_pkg::SEL_NONE: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Level decoder.

	vdrv_if drv_io ();

	assign drv_io.transfer_clock        = transfer_clock;
	assign drv_io.sense_gate            = sense_gate;
	assign drv_io.vertical_signal_23    = vertical_signal_23;
	assign drv_io.vertical_signal_24    = vertical_signal_24;
	assign drv_io.general_output_5      = general_output_5;
	assign drv_io.general_output_6      = general_output_6;
	assign drv_io.legacy_channel_select = legacy_q;

	vdrv_level_decoder u_decoder (
		.pclk    (pclk),
		.presetn (presetn),
		.drv_io  (drv_io.decoder)
	);

	assign drive_channel_1a = drv_io.level[0];
	assign drive_channel_1b = drv_io.level[1];
	assign drive_channel_2a = drv_io.level[2];
	assign drive_channel_2b = drv_io.level[3];
	assign drive_channel_3a = drv_io.level[4];
	assign drive_channel_3b = drv_io.level[5];
	assign drive_channel_4  = drv_io.level[6];
	assign drive_channel_5  = drv_io.level[7];
	assign drive_channel_6  = drv_io.level[8];
	assign drive_channel_7  = drv_io.level[9];
	assign drive_channel_8  = drv_io.level[10];

endmodule
`default_nettype wire

// *** test/ccd_sensor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccd_sensor_model (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Gate drive levels, channel 1a in the top pair, channel 8 in the bottom pair.
	input  wire logic [21:0] drive,
	// Sticky flag for a level that the gates cannot take.
	output logic             bad_code
);
	////////////////////////////////
	// The two-level gates 7 and 8 never take the high level, and no gate takes code 11.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bad_code <= 1'b0;
		end else begin
			for (int k = 0; k < 11; k++) begin
				if (drive[2*k+:2] == 2'b11 || (k < 2 && drive[2*k+:2] == 2'b10)) begin
					bad_code <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** test/ccd_vertical_field_sequencer_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccd_vertical_field_sequencer_monitor (
	// Clock and reset.
	input wire logic        pclk,
	input wire logic        presetn,
	// Bus.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	// Timing inputs.
	input wire logic        vertical_sync,
	input wire logic [8:1]  transfer_clock,
	input wire logic [7:1]  sense_gate,
	input wire logic        vertical_signal_23,
	input wire logic        vertical_signal_24,
	input wire logic        general_output_5,
	input wire logic        general_output_6,
	// Outputs.
	input wire logic [2:0]  sequence_position,
	input wire logic [1:0]  drive_channel_1a,
	input wire logic [1:0]  drive_channel_1b,
	input wire logic [1:0]  drive_channel_2a,
	input wire logic [1:0]  drive_channel_2b,
	input wire logic [1:0]  drive_channel_3a,
	input wire logic [1:0]  drive_channel_3b,
	input wire logic [1:0]  drive_channel_4,
	input wire logic [1:0]  drive_channel_5,
	input wire logic [1:0]  drive_channel_6,
	input wire logic [1:0]  drive_channel_7,
	input wire logic [1:0]  drive_channel_8
);
	logic        up_q;
	logic        leg_q;
	logic        wr_q;
	logic        vs_q;
	logic [5:0]  fall_q;
	logic [19:0] in_q;

	function automatic logic [1:0] dec(input logic x, input logic g);
		return x ? 2'b00 : (g ? 2'b01 : 2'b10);
	endfunction

	////////////////////////////////
	// Inputs and legacy select as the decoder saw them at the previous edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_q   <= 1'b0;
			leg_q  <= 1'b0;
			wr_q   <= 1'b0;
			vs_q   <= 1'b1;
			fall_q <= 6'h0;
			in_q   <= 20'h0;
		end else begin
			up_q   <= 1'b1;
			wr_q   <= psel && penable && pwrite;
			vs_q   <= vertical_sync;
			fall_q <= {fall_q[4:0], vs_q & ~vertical_sync};
			in_q   <= {leg_q, general_output_6, general_output_5, vertical_signal_24, vertical_signal_23,
				sense_gate, transfer_clock};
			if (psel && penable && pwrite && paddr == 32'h300) begin
				leg_q <= pwdata[0];
			end
		end
	end

	////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ch1a_level: assert property (up_q |-> drive_channel_1a == dec(in_q[0], in_q[8]))
		else $error("Channel 1a level wrong.");
	a_ch1b_level: assert property (up_q |-> drive_channel_1b == dec(in_q[0], in_q[9]))
		else $error("Channel 1b level wrong.");
	a_ch2a_level: assert property (up_q |-> drive_channel_2a == dec(in_q[1], in_q[10]))
		else $error("Channel 2a level wrong.");
	a_ch2b_level: assert property (up_q |-> drive_channel_2b == dec(in_q[1], in_q[11]))
		else $error("Channel 2b level wrong.");
	a_ch3a_level: assert property (up_q |-> drive_channel_3a == dec(in_q[2], in_q[12]))
		else $error("Channel 3a level wrong.");
	a_ch3b_level: assert property (up_q |-> drive_channel_3b == dec(in_q[19] ? in_q[15] : in_q[2], in_q[13]))
		else $error("Channel 3b level wrong.");
	a_ch4_level: assert property (up_q |-> drive_channel_4 == dec(in_q[3], in_q[14]))
		else $error("Channel 4 level wrong.");
	a_ch5_level: assert property (up_q |-> drive_channel_5 == dec(in_q[4], in_q[19] ? in_q[17] : in_q[15]))
		else $error("Channel 5 level wrong.");
	a_ch6_level: assert property (up_q |-> drive_channel_6 == dec(in_q[5], in_q[19] ? in_q[18] : in_q[16]))
		else $error("Channel 6 level wrong.");
	a_ch7_two_level: assert property (up_q |-> drive_channel_7 == (in_q[6] ? 2'b00 : 2'b01))
		else $error("Channel 7 level wrong.");
	a_ch8_two_level: assert property (up_q |-> drive_channel_8 == (in_q[7] ? 2'b00 : 2'b01))
		else $error("Channel 8 level wrong.");
	a_pos_step: assert property ($changed(sequence_position) |->
		sequence_position == 3'h0 || sequence_position == $past(sequence_position) + 3'h1)
		else $error("Sequence position jumped.");
	a_pos_cause: assert property (up_q && $changed(sequence_position) |-> (|fall_q) || wr_q)
		else $error("Sequence position moved without sync or write.");

	c_legacy_on: cover property (wr_q && leg_q);
	c_pos_wrap: cover property ($changed(sequence_position) && sequence_position == 3'h0);
	c_high_level: cover property (drive_channel_1a == 2'b10);
endmodule

bind ccd_vertical_field_sequencer ccd_vertical_field_sequencer_monitor mon (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .vertical_sync, .transfer_clock, .sense_gate,
	.vertical_signal_23, .vertical_signal_24, .general_output_5, .general_output_6, .sequence_position,
	.drive_channel_1a, .drive_channel_1b, .drive_channel_2a, .drive_channel_2b, .drive_channel_3a,
	.drive_channel_3b, .drive_channel_4, .drive_channel_5, .drive_channel_6, .drive_channel_7, .drive_channel_8
);
`default_nettype wire

// *** test/tb_ccd_vertical_field_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_ccd_vertical_field_sequencer;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic        vertical_sync;
	logic [8:1]  transfer_clock;
	logic [7:1]  sense_gate;
	logic        vertical_signal_23;
	logic        vertical_signal_24;
	logic        general_output_5;
	logic        general_output_6;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire  [4:0]  current_field;
	wire  [2:0]  sequence_position;
	wire  [21:0] chv;
	wire         bad_code;
	int          num_errors;
	int          cmp_count;
	logic [24:0] lo;
	logic [9:0]  hi;

	ccd_vertical_field_sequencer dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.vertical_sync, .transfer_clock, .sense_gate, .vertical_signal_23, .vertical_signal_24,
		.general_output_5, .general_output_6, .current_field, .sequence_position,
		.drive_channel_1a(chv[21:20]), .drive_channel_1b(chv[19:18]), .drive_channel_2a(chv[17:16]),
		.drive_channel_2b(chv[15:14]), .drive_channel_3a(chv[13:12]), .drive_channel_3b(chv[11:10]),
		.drive_channel_4(chv[9:8]), .drive_channel_5(chv[7:6]), .drive_channel_6(chv[5:4]),
		.drive_channel_7(chv[3:2]), .drive_channel_8(chv[1:0])
	);
	ccd_sensor_model sensor (.pclk, .presetn, .drive(chv), .bad_code);

	always #2.5 pclk = ~pclk;

	////////////////////////////////
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
			num_errors++;
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check("bus answer", 32'h0, {31'h0, n >= 50});
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		check(nm, exp, q);
		check({nm, " error flag"}, {31'h0, experr}, {31'h0, e});
	endtask

	task automatic see_state(input logic [31:0] p, input logic [31:0] f);
		check("position", p, {29'h0, sequence_position});
		check("field", f, {27'h0, current_field});
	endtask

	// One field boundary: the falling sync edge needs three edges to reach the sequencer.
	task automatic sync_pulse(input logic [31:0] p, input logic [31:0] f);
		vertical_sync <= 1'b0;
		repeat (4) @(posedge pclk);
		vertical_sync <= 1'b1;
		repeat (6) @(posedge pclk);
		see_state(p, f);
	endtask

	function automatic logic [1:0] lv(input logic x, input logic g);
		return x ? 2'b00 : (g ? 2'b01 : 2'b10);
	endfunction

	////////////////////////////////
	task automatic t_registers();
		logic [31:0] q;
		logic        e;
		rd("count after reset", 32'ha8, 32'h1, 1'b0);
		rd("unmapped read", 32'h3fc, 32'h0, 1'b1);
		rd("unaligned read", 32'ha9, 32'h0, 1'b1);
		apb(1'b1, 32'h3fc, 32'hffffffff, q, e);
		check("unmapped write error flag", 32'h1, {31'h0, e});
	endtask

	task automatic t_decode();
		logic [31:0] w;
		logic [21:0] ex;
		for (int i = 0; i < 128; i++) begin
			w = i * 32'h9e3779b9;
			if (i % 64 == 0) wr(32'h300, {31'h0, i[6]});
			transfer_clock     <= w[7:0];
			sense_gate         <= w[14:8];
			vertical_signal_23 <= w[15];
			vertical_signal_24 <= w[16];
			general_output_5   <= w[17];
			general_output_6   <= w[18];
			ex = {lv(w[0], w[8]), lv(w[0], w[9]), lv(w[1], w[10]), lv(w[1], w[11]), lv(w[2], w[12]),
				lv(i[6] ? w[15] : w[2], w[13]), lv(w[3], w[14]), lv(w[4], i[6] ? w[17] : w[15]),
				lv(w[5], i[6] ? w[18] : w[16]), lv(w[6], 1'b1), lv(w[7], 1'b1)};
			repeat (2) @(posedge pclk);
			check("levels", {10'h0, ex}, {10'h0, chv});
		end
		rd("legacy select", 32'h300, 32'h1, 1'b0);
	endtask

	task automatic t_sequence();
		int c;
		for (int k = 0; k < 5; k++) lo[5*k+:5] = 5'd9 + 5'(k);
		hi = {5'd15, 5'd14};
		for (int j = 0; j < 3; j++) begin
			c = (j == 0) ? 1 : 4 * j - 1;
			wr(32'ha8, c);
			wr(32'hac, {7'h0, lo});
			wr(32'hb0, {22'h0, hi});
			repeat (2) @(posedge pclk);
			see_state(0, 9);
			for (int s = 1; s <= c + 1; s++) sync_pulse(s % c, 9 + s % c);
		end
		rd("low slots", 32'hac, {7'h0, lo}, 1'b0);
		rd("high slots", 32'hb0, {22'h0, hi}, 1'b0);
		sync_pulse(2, 11);
		wr(32'ha8, 32'h7);
		wr(32'hac, {7'h0, lo});
		see_state(2, 11);
		wr(32'hb0, {22'h0, hi});
		repeat (2) @(posedge pclk);
		see_state(0, 9);
	endtask

	task automatic t_sync_update();
		wr(32'h2d0, 32'h3ff);
		wr(32'h2d4, 32'hfc00);
		rd("update low", 32'h2d0, 32'h3ff, 1'b0);
		rd("update high", 32'h2d4, 32'hfc00, 1'b0);
		wr(32'hac, {7'h0, lo[24:5], 5'd20});
		wr(32'ha8, 32'h2);
		wr(32'hb0, {22'h0, hi});
		repeat (2) @(posedge pclk);
		see_state(0, 9);
		rd("status", 32'h304, 32'h00120900, 1'b0);
		sync_pulse(1, 10);
		sync_pulse(0, 20);
		sync_pulse(1, 10);
		sync_pulse(0, 20);
		wr(32'h2d0, 32'h0);
		wr(32'h2d4, 32'h0);
	endtask

	task automatic print_verdict();
		$display("Comparisons: %0d, mismatches: %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	////////////////////////////////
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		vertical_sync = 1'b1;
		transfer_clock = 8'hff;
		sense_gate = 7'h0;
		vertical_signal_23 = 1'b0;
		vertical_signal_24 = 1'b0;
		general_output_5 = 1'b0;
		general_output_6 = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_registers();
		t_decode();
		t_sequence();
		t_sync_update();
		check("sensor flag", 32'h0, {31'h0, bad_code});
		print_verdict();
	end

	initial begin
		repeat (8000) @(posedge pclk);
		num_errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
